/* File: inc/excl_mon_pkg.sv */
// Purpose: shared constants and types for the exclusive access monitor
// Assumes: one core clock, no software-visible registers
// Notes:   size codes follow the exclusive load/store variants
package excl_mon_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    typedef enum logic [1:0] {
        SIZE_BYTE,
        SIZE_HALF,
        SIZE_WORD,
        SIZE_NONE
    } acc_size_t;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_LOAD,
        OP_STORE,
        OP_CLEAR
    } excl_op_t;

    localparam logic [DATA_W-1:0] STATUS_OK   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] STATUS_FAIL = 32'h0000_0001;
    localparam logic              TAG_RESET   = 1'b0;
    localparam logic [3:0]        STRB_NONE   = 4'h0;
    localparam logic [3:0]        STRB_BYTE0   = 4'h1;
    localparam logic [3:0]        STRB_HALF_LO = 4'h3;
    localparam logic [3:0]        STRB_HALF_HI = 4'hc;
    localparam logic [3:0]        STRB_WORD    = 4'hf;
    localparam logic              FLAG_RESET   = 1'b0;
    localparam logic [ADDR_W-1:0] ADDR_RESET   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] WDATA_RESET  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] STATUS_RESET = 32'h0000_0000;
endpackage

/* File: design/excl_lane_ctl.sv */
// Purpose: byte-lane strobes for byte, halfword and word accesses
// Assumes: little-endian lane order, naturally aligned addresses
// Notes:   combinational; registered by the caller
`timescale 1ns/1ns
module excl_lane_ctl
    import excl_mon_pkg::*;
(
    input  wire logic [1:0] addr_lo_i,
    input  wire acc_size_t  size_i,
    output logic [3:0]      strb_o
);
    always_comb begin
        case (size_i)
            SIZE_BYTE: strb_o = STRB_BYTE0 << addr_lo_i;
            SIZE_HALF: strb_o = addr_lo_i[1] ? STRB_HALF_HI
                                             : STRB_HALF_LO;
            SIZE_WORD: strb_o = STRB_WORD;
            default:   strb_o = STRB_NONE;
        endcase
    end
endmodule

/* File: design/excl_monitor.sv */
// Purpose: local exclusive monitor of a core
// Assumes: global monitor answers GLB_OK_I in the store request cycle
// Notes:   one request per cycle; exception has priority over any op
`timescale 1ns/1ns
module excl_monitor
    import excl_mon_pkg::*;
(
    input  wire logic              MCLK_I,
    input  wire logic              RST_I,
    input  wire logic              LOAD_EXCL_I,
    input  wire logic              STORE_EXCL_I,
    input  wire logic              CLEAR_EXCLUSIVE_TAG_I,
    input  wire logic              EXC_ENTRY_I,
    input  wire acc_size_t         SIZE_I,
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic [DATA_W-1:0] WDATA_I,
    input  wire logic              GLB_OK_I,
    output logic                   MEM_RD_O,
    output logic                   MEM_WR_O,
    output logic [ADDR_W-1:0]      MEM_ADDR_O,
    output logic [DATA_W-1:0]      MEM_WDATA_O,
    output logic [3:0]             MEM_STRB_O,
    output logic                   GLB_SET_O,
    output logic                   GLB_CLR_O,
    output logic                   STATUS_VLD_O,
    output logic [DATA_W-1:0]      STATUS_O,
    output logic                   TAG_O
);
    logic       tag_q;
    logic       tag_d;
    excl_op_t   op;
    logic       is_load;
    logic       is_store;
    logic       grant;
    logic [3:0] strb;

    // exception beats any instruction in the same cycle
    function automatic excl_op_t decode_op(
        input logic exc,
        input logic ld,
        input logic st,
        input logic cl
    );
        excl_op_t res;
        res = OP_NONE;
        if (!exc) begin
            if (ld) begin
                res = OP_LOAD;
            end else if (st) begin
                res = OP_STORE;
            end else if (cl) begin
                res = OP_CLEAR;
            end
        end
        return res;
    endfunction

    // both local and global tag must still be held
    function automatic logic store_granted(
        input excl_op_t o,
        input logic     local_tag,
        input logic     global_ok
    );
        return (o == OP_STORE) && local_tag && global_ok;
    endfunction

    // failed stores and idle cycles drive no lanes
    function automatic logic [3:0] lanes_used(
        input logic       rd,
        input logic       wr_ok,
        input logic [3:0] lanes
    );
        logic [3:0] res;
        res = STRB_NONE;
        if (rd || wr_ok) begin
            res = lanes;
        end
        return res;
    endfunction

    // whole word, so software never sees stale upper bits
    function automatic logic [DATA_W-1:0] status_word(
        input logic ok
    );
        logic [DATA_W-1:0] res;
        res = STATUS_FAIL;
        if (ok) begin
            res = STATUS_OK;
        end
        return res;
    endfunction

    assign op       = decode_op(EXC_ENTRY_I, LOAD_EXCL_I, STORE_EXCL_I,
                                CLEAR_EXCLUSIVE_TAG_I);
    assign is_load  = (op == OP_LOAD);
    assign is_store = (op == OP_STORE);
    assign grant    = store_granted(op, tag_q, GLB_OK_I);

    excl_lane_ctl u_lane (
        .addr_lo_i (ADDR_I[1:0]),
        .size_i    (SIZE_I),
        .strb_o    (strb)
    );

    // next local tag
    always_comb begin
        tag_d = tag_q;
        case (op)
            OP_LOAD:  tag_d = 1'b1;
            OP_STORE: tag_d = 1'b0;
            OP_CLEAR: tag_d = 1'b0;
            default:  tag_d = tag_q;
        endcase
        if (EXC_ENTRY_I) begin
            tag_d = 1'b0;
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            tag_q <= TAG_RESET;
        end else begin
            tag_q <= tag_d;
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            MEM_RD_O <= FLAG_RESET;
        end else begin
            MEM_RD_O <= is_load;
        end
    end

    // failed store never reaches memory
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            MEM_WR_O <= FLAG_RESET;
        end else begin
            MEM_WR_O <= grant;
        end
    end

    // address and data simply follow the request every cycle
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            MEM_ADDR_O <= ADDR_RESET;
        end else begin
            MEM_ADDR_O <= ADDR_I;
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            MEM_WDATA_O <= WDATA_RESET;
        end else begin
            MEM_WDATA_O <= WDATA_I;
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            MEM_STRB_O <= STRB_NONE;
        end else begin
            MEM_STRB_O <= lanes_used(is_load, grant, strb);
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            GLB_SET_O <= FLAG_RESET;
        end else begin
            GLB_SET_O <= is_load;
        end
    end

    // clear instruction alone does not touch global tags
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            GLB_CLR_O <= FLAG_RESET;
        end else begin
            GLB_CLR_O <= EXC_ENTRY_I || is_store;
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            STATUS_VLD_O <= FLAG_RESET;
        end else begin
            STATUS_VLD_O <= is_store;
        end
    end

    // status holds until the next store, granted or failed
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            STATUS_O <= STATUS_RESET;
        end else begin
            if (is_store) begin
                STATUS_O <= status_word(grant);
            end
        end
    end

    // visible tag lags the internal one by a cycle
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            TAG_O <= TAG_RESET;
        end else begin
            TAG_O <= tag_q;
        end
    end
endmodule

/* File: tb/excl_props.sv */
// Purpose: port checker for the exclusive monitor
// Assumes: one clock, requests sampled on the rising edge
// Notes:   tag output lags the internal tag by a cycle
`timescale 1ns/1ns
module excl_props
    import excl_mon_pkg::*;
(
    input wire logic              MCLK_I,
    input wire logic              RST_I,
    input wire logic              LOAD_EXCL_I,
    input wire logic              STORE_EXCL_I,
    input wire logic              CLEAR_EXCLUSIVE_TAG_I,
    input wire logic              EXC_ENTRY_I,
    input wire logic              GLB_OK_I,
    input wire logic              MEM_RD_O,
    input wire logic              MEM_WR_O,
    input wire logic [3:0]        MEM_STRB_O,
    input wire logic              GLB_CLR_O,
    input wire logic              STATUS_VLD_O,
    input wire logic              TAG_O,
    input wire logic [DATA_W-1:0] STATUS_O
);
    wire ld = LOAD_EXCL_I & !EXC_ENTRY_I;
    wire st = STORE_EXCL_I & !LOAD_EXCL_I & !EXC_ENTRY_I;
    // an exception in the same cycle would clear the global tags too
    wire cl = CLEAR_EXCLUSIVE_TAG_I & !STORE_EXCL_I & !LOAD_EXCL_I
              & !EXC_ENTRY_I;
    default clocking @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);
    sequence read_s;
        MEM_RD_O ##1 TAG_O;
    endsequence
    sequence drop_s;
        GLB_CLR_O ##1 !TAG_O;
    endsequence
    sequence keep_s;
        !GLB_CLR_O ##1 !TAG_O;
    endsequence
    property ld_p;
        ld |=> read_s;
    endproperty
    property rd_p;
        MEM_RD_O |-> $past(ld);
    endproperty
    property wr_p;
        MEM_WR_O |-> STATUS_O == STATUS_OK && $past(GLB_OK_I);
    endproperty
    property no_p;
        st && !GLB_OK_I |=> !MEM_WR_O && STATUS_O == STATUS_FAIL
                            && MEM_STRB_O == STRB_NONE;
    endproperty
    property vld_p;
        STATUS_VLD_O |-> $past(st);
    endproperty
    property st_p;
        st |=> drop_s;
    endproperty
    property ex_p;
        EXC_ENTRY_I |=> drop_s;
    endproperty
    property cl_p;
        cl |=> keep_s;
    endproperty
    AST_LD: assert property (ld_p) else $error("load");
    AST_RD: assert property (rd_p) else $error("rd");
    AST_WR: assert property (wr_p) else $error("wr");
    AST_NO: assert property (no_p) else $error("fail");
    AST_VLD: assert property (vld_p) else $error("vld");
    AST_ST: assert property (st_p) else $error("store");
    AST_EX: assert property (ex_p) else $error("exc");
    AST_CL: assert property (cl_p) else $error("clr");
endmodule
bind excl_monitor excl_props chk (
    .MCLK_I                (MCLK_I),
    .RST_I                 (RST_I),
    .LOAD_EXCL_I           (LOAD_EXCL_I),
    .STORE_EXCL_I          (STORE_EXCL_I),
    .CLEAR_EXCLUSIVE_TAG_I (CLEAR_EXCLUSIVE_TAG_I),
    .EXC_ENTRY_I           (EXC_ENTRY_I),
    .GLB_OK_I              (GLB_OK_I),
    .MEM_RD_O              (MEM_RD_O),
    .MEM_WR_O              (MEM_WR_O),
    .MEM_STRB_O            (MEM_STRB_O),
    .GLB_CLR_O             (GLB_CLR_O),
    .STATUS_VLD_O          (STATUS_VLD_O),
    .TAG_O                 (TAG_O),
    .STATUS_O              (STATUS_O)
);

/* File: tb/glb_model.sv */
// Purpose: global exclusive monitor of the system
// Assumes: steal stands for a write by another core
// Notes:   clear instruction never reaches it
`timescale 1ns/1ns
module glb_model(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    input  wire logic steal_i,
    output logic      ok_o
);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) ok_o <= 1'h0;
        else if (clr_i | steal_i) ok_o <= 1'h0;
        else if (set_i) ok_o <= 1'h1;
    end
endmodule

/* File: tb/exclusive_access_monitor_bench.sv */
// Purpose: bench for the exclusive monitor
// Assumes: one idle cycle between requests
// Notes:   no random stimulus
`timescale 1ns/1ns
module exclusive_access_monitor_bench;
    import excl_mon_pkg::*;
    logic clk = 0, rst = 1, ld = 0, st = 0, cl = 0, ex = 0, steal = 0;
    logic rd, wr, vld, tg, gset, gclr, ok;
    logic [3:0] strb;
    logic [31:0] adr = 0, sts, maddr, mwdata;
    acc_size_t sz = SIZE_WORD;
    int errors = 0, n_checks = 0;
    excl_monitor uut(.MCLK_I(clk), .RST_I(rst), .LOAD_EXCL_I(ld),
        .STORE_EXCL_I(st), .CLEAR_EXCLUSIVE_TAG_I(cl), .EXC_ENTRY_I(ex),
        .SIZE_I(sz), .ADDR_I(adr), .WDATA_I(adr), .GLB_OK_I(ok),
        .MEM_RD_O(rd), .MEM_WR_O(wr), .MEM_ADDR_O(maddr),
        .MEM_WDATA_O(mwdata), .MEM_STRB_O(strb), .GLB_SET_O(gset),
        .GLB_CLR_O(gclr), .STATUS_VLD_O(vld), .STATUS_O(sts), .TAG_O(tg));
    glb_model gm(.clk_i(clk), .rst_i(rst), .set_i(gset), .clr_i(gclr),
        .steal_i(steal), .ok_o(ok));
    initial forever #25 clk = ~clk;
    task chk(string n, logic [31:0] g, e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    task op(logic [4:0] v);
        @(posedge clk) #1 {steal, ex, ld, st, cl} = v;
        @(posedge clk) #1 {steal, ex, ld, st, cl} = 5'h0;
    endtask
    task store(logic [31:0] e);
        op(5'h2);
        chk("status", sts, e);
        chk("wr", {31'h0, wr}, {31'h0, ~e[0]});
        chk("vld", {31'h0, vld}, 32'h1);
        chk("gclr", {31'h0, gclr}, 32'h1);
    endtask
    task s_pair(acc_size_t s, logic [1:0] a, logic [3:0] e);
        sz = s;
        adr = {30'h0, a};
        op(5'h4);
        chk("rd", 32'(rd & gset), 32'h1);
        chk("raddr", maddr, adr);
        chk("rstrb", 32'(strb), 32'(e));
        store(32'h0);
        chk("tag", 32'(tg), 32'h1);
        chk("wdata", mwdata, adr);
        chk("wstrb", 32'(strb), 32'(e));
        store(32'h1);
        chk("tag", 32'(tg), 32'h0);
    endtask
    task kill(logic [4:0] v, logic g, t);
        op(5'h4);
        op(v);
        chk("gclr", 32'(gclr), 32'(g));
        store(32'h1);
        chk("tag", 32'(tg), 32'(t));
        chk("wstrb", 32'(strb), 32'h0);
    endtask
    task results;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 rst = 0;
        chk("tag", 32'(tg), 32'h0);
        s_pair(SIZE_BYTE, 2'h3, 4'h8);
        s_pair(SIZE_HALF, 2'h2, 4'hc);
        s_pair(SIZE_WORD, 2'h0, 4'hf);
        kill(5'h01, 1'b0, 1'b0);
        kill(5'h08, 1'b1, 1'b0);
        kill(5'h10, 1'b0, 1'b1);
        results;
    end
    initial begin
        #20000;
        errors++;
        results;
    end
endmodule
